// *** rtl/csp_pkg.sv ***
// Purpose: shared constants and types of the clocked serial output path
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register
// Notes:   offsets are byte addresses; field positions refer to bit numbers
package csp_pkg;

  localparam int unsigned BITS_PER_XFER = 8;
  localparam int unsigned ADDR_W        = 5;

  localparam logic [ADDR_W-1:0] OFS_CTRL    = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CLKSEL  = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_TXBUF   = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_SHIFT   = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST  = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_PIN     = 5'h18;

  // control register fields
  localparam int unsigned POS_ENABLE = 7;
  localparam int unsigned POS_TRMD   = 6;
  localparam int unsigned POS_DIR    = 4;
  localparam int unsigned POS_BUSY   = 0;
  // clock selection register fields
  localparam int unsigned POS_CKP    = 4;
  localparam int unsigned POS_DAP    = 3;
  // interrupt status and mask field
  localparam int unsigned POS_DONE   = 0;
  // pin register fields
  localparam int unsigned POS_PIN_DIR   = 0;
  localparam int unsigned POS_PIN_LATCH = 1;

  localparam logic [7:0] RST_TXBUF     = 8'h00;
  localparam logic [7:0] RST_SHIFT     = 8'h00;
  localparam logic       RST_PIN_DIR   = 1'b1;
  localparam logic       RST_PIN_LATCH = 1'b0;
  localparam logic       RST_MASK      = 1'b0;
  localparam logic [3:0] LAST_BIT_IDX  = 4'h7;

  typedef struct packed {
    logic enable;
    logic trmd;
    logic dir;
    logic ckp;
    logic dap;
  } csp_cfg_s;

  localparam csp_cfg_s RST_CFG = '{enable: 1'b0, trmd: 1'b0, dir: 1'b0, ckp: 1'b0, dap: 1'b0};

  typedef enum logic [1:0] {
    ST_IDLE       = 2'b00,
    ST_WAIT_FIRST = 2'b01,
    ST_SHIFT      = 2'b10
  } csp_state_e;

endpackage

// *** rtl/csp_sync.sv ***
// Purpose: two-flop synchroniser for pins that arrive from outside the clock domain
// Assumes: each bit is an independent level
// Notes:   the first flop feeds only the second
module csp_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta <= '0;
      o_q  <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule

// *** rtl/csp_top.sv ***
// Purpose: data-output path of an 8-bit three-wire clocked serial interface
// Assumes: serial clock comes from the partner and is much slower than i_mclk
// Notes:   serial clock and serial input are sampled, edges found on i_mclk

// What this block does
// - four timing types from polarity and phase bits: 00, 01, 10, 11
// - a started transfer sends the transmit buffer out, first bit first
// - phase 0: first bit goes buffer to output latch on the output edge
// - phase 0: next opposite edge loads buffer into shifter, shifts, captures input
// - phase 0: later bits go shifter to output latch on each output edge
// - phase 1: first bit latched at the buffer write or shifter read strobe
// - phase 1: next capture edge loads buffer into shifter, shifts, captures input
// - phase 1: later bits go shifter to output latch on each following output edge
// - after a finished transfer the output keeps the last bit
// - disabled in receive-only mode the output is low, also after reset
// - disabled, transmit mode, phase 0: output shows its latch, which is low
// - disabled, transmit mode, phase 1: output shows buffer bit 7 or bit 0
// - disabled, writing mode, phase or order bits changes the output at once
// - pin level comes from pin direction, pin latch and serial output
// - 8-bit transfers set busy at start, done flag and clear busy after bit 8
// - transmit mode starts on buffer write, receive-only on shifter read
// - clearing enable stops and clears busy flag and shifter
module csp_top
  import csp_pkg::*;
#(
  parameter int unsigned DATA_W = BITS_PER_XFER
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  input  wire logic              i_serial_clock_line,
  input  wire logic              i_serial_in_line,
  output logic                   o_serial_out_line,
  output logic                   o_serial_out_oe,
  output logic                   o_irq
);

  if (DATA_W != BITS_PER_XFER)
  begin : g_width_check
    $error("csp_top: only 8-bit transfers are supported");
  end

  logic [1:0]  pins_s;
  logic        sck_s;
  logic        si_s;

  csp_sync #(
    .WIDTH (2)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_serial_clock_line, i_serial_in_line}),
    .o_q     (pins_s)
  );

  assign sck_s = pins_s[1];
  assign si_s  = pins_s[0];

  csp_cfg_s   cfg;
  csp_cfg_s   next_cfg;
  csp_state_e state;
  csp_state_e next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] transmit_buffer;
  logic [7:0] next_transmit_buffer;
  logic [7:0] shift_register;
  logic [7:0] next_shift_register;
  logic       so_latch;
  logic       next_so_latch;
  logic       done_st;
  logic       next_done_st;
  logic       done_mask;
  logic       next_done_mask;
  logic       pin_direction_setting;
  logic       next_pin_direction_setting;
  logic       pin_output_latch;
  logic       next_pin_output_latch;
  logic       ack;
  logic       next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic       sck_d;
  logic       next_sck_d;

  logic       req;
  logic       wr_acc;
  logic       rd_acc;
  logic       sck_rise;
  logic       sck_fall;
  logic       cap_edge;
  logic       out_edge;
  logic       start;
  logic       busy;
  logic [7:0] cap_word;
  logic       serial_out_value;

  // first bit of a byte in the selected order
  function automatic logic first_bit(input logic [7:0] d, input logic dir);
    first_bit = dir ? d[0] : d[7];
  endfunction

  // byte after one shift with the received bit entering at the tail
  function automatic logic [7:0] shift_in(input logic [7:0] d, input logic dir, input logic b);
    shift_in = dir ? {b, d[7:1]} : {d[6:0], b};
  endfunction

  assign req               = i_avs_read | i_avs_write;
  // one wait cycle per access so read data can come from a flop
  assign o_avs_waitrequest = req & ~ack;
  assign wr_acc            = i_avs_write & ack;
  assign rd_acc            = i_avs_read & ack;
  assign o_avs_readdata    = rdata;
  assign busy              = (state != ST_IDLE);

  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;
  // capture edge is rising for types 1 and 4, falling for types 2 and 3
  assign cap_edge = (cfg.ckp ^ cfg.dap) ? sck_fall : sck_rise;
  assign out_edge = (cfg.ckp ^ cfg.dap) ? sck_rise : sck_fall;

  always_comb
  begin
    start = 1'b0;
    if (cfg.enable && !busy)
    begin
      if (cfg.trmd)
      begin
        start = wr_acc && (i_avs_address == OFS_TXBUF);
      end
      else
      begin
        start = rd_acc && (i_avs_address == OFS_SHIFT);
      end
    end
  end

  always_comb
  begin
    next_ack                   = req & ~ack;
    next_rdata                 = rdata;
    next_cfg                   = cfg;
    next_transmit_buffer       = transmit_buffer;
    next_done_mask             = done_mask;
    next_pin_direction_setting = pin_direction_setting;
    next_pin_output_latch      = pin_output_latch;
    next_done_st               = done_st;
    next_state                 = state;
    next_cnt                   = cnt;
    next_shift_register        = shift_register;
    next_so_latch              = so_latch;
    next_sck_d                 = sck_s;
    cap_word                   = '0;

    if (i_avs_read && !ack)
    begin
      case (i_avs_address)
        OFS_CTRL:
        begin
          next_rdata                = '0;
          next_rdata[POS_ENABLE]    = cfg.enable;
          next_rdata[POS_TRMD]      = cfg.trmd;
          next_rdata[POS_DIR]       = cfg.dir;
          next_rdata[POS_BUSY]      = busy;
        end
        OFS_CLKSEL:
        begin
          next_rdata                = '0;
          next_rdata[POS_CKP]       = cfg.ckp;
          next_rdata[POS_DAP]       = cfg.dap;
        end
        OFS_TXBUF:   next_rdata = {24'h000000, transmit_buffer};
        OFS_SHIFT:   next_rdata = {24'h000000, shift_register};
        OFS_IRQ_ST:  next_rdata = {31'h00000000, done_st};
        OFS_IRQ_MSK: next_rdata = {31'h00000000, done_mask};
        OFS_PIN:
        begin
          next_rdata                = '0;
          next_rdata[POS_PIN_DIR]   = pin_direction_setting;
          next_rdata[POS_PIN_LATCH] = pin_output_latch;
        end
        default:     next_rdata = '0;
      endcase
    end

    if (wr_acc && i_avs_byteenable[0])
    begin
      case (i_avs_address)
        OFS_CTRL:
        begin
          next_cfg.enable = i_avs_writedata[POS_ENABLE];
          next_cfg.trmd   = i_avs_writedata[POS_TRMD];
          next_cfg.dir    = i_avs_writedata[POS_DIR];
        end
        OFS_CLKSEL:
        begin
          next_cfg.ckp    = i_avs_writedata[POS_CKP];
          next_cfg.dap    = i_avs_writedata[POS_DAP];
        end
        OFS_TXBUF:   next_transmit_buffer = i_avs_writedata[7:0];
        OFS_IRQ_ST:
        begin
          if (i_avs_writedata[POS_DONE])
          begin
            next_done_st = 1'b0;
          end
        end
        OFS_IRQ_MSK: next_done_mask = i_avs_writedata[POS_DONE];
        OFS_PIN:
        begin
          next_pin_direction_setting = i_avs_writedata[POS_PIN_DIR];
          next_pin_output_latch      = i_avs_writedata[POS_PIN_LATCH];
        end
        default:
        begin
        end
      endcase
    end

    case (state)
      ST_IDLE:
      begin
        if (start)
        begin
          next_cnt = '0;
          if (cfg.dap)
          begin
            // strobe ends at this edge; buffer value may be the one being written
            next_so_latch = first_bit(next_transmit_buffer, cfg.dir);
            next_state    = ST_SHIFT;
          end
          else
          begin
            next_state    = ST_WAIT_FIRST;
          end
        end
      end
      ST_WAIT_FIRST:
      begin
        if (out_edge)
        begin
          next_so_latch = first_bit(transmit_buffer, cfg.dir);
          next_state    = ST_SHIFT;
        end
      end
      ST_SHIFT:
      begin
        if (cap_edge)
        begin
          // first capture loads the buffer and shifts in the same step
          cap_word            = (cnt == 4'h0) ? transmit_buffer : shift_register;
          next_shift_register = shift_in(cap_word, cfg.dir, si_s);
          next_cnt            = cnt + 4'h1;
          if (cnt == LAST_BIT_IDX)
          begin
            // output latch is left alone so the last bit stays on the line
            next_state   = ST_IDLE;
            next_done_st = 1'b1;
          end
        end
        else if (out_edge && (cnt != 4'h0))
        begin
          next_so_latch = first_bit(shift_register, cfg.dir);
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase

    // done set above overrides a clear written in the same cycle
    if (!cfg.enable)
    begin
      next_state          = ST_IDLE;
      next_cnt            = '0;
      next_shift_register = '0;
      next_so_latch       = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ack                   <= 1'b0;
      rdata                 <= '0;
      cfg                   <= RST_CFG;
      transmit_buffer       <= RST_TXBUF;
      shift_register        <= RST_SHIFT;
      done_st               <= 1'b0;
      done_mask             <= RST_MASK;
      pin_direction_setting <= RST_PIN_DIR;
      pin_output_latch      <= RST_PIN_LATCH;
      state                 <= ST_IDLE;
      cnt                   <= '0;
      so_latch              <= 1'b0;
      sck_d                 <= 1'b0;
    end
    else
    begin
      ack                   <= next_ack;
      rdata                 <= next_rdata;
      cfg                   <= next_cfg;
      transmit_buffer       <= next_transmit_buffer;
      shift_register        <= next_shift_register;
      done_st               <= next_done_st;
      done_mask             <= next_done_mask;
      pin_direction_setting <= next_pin_direction_setting;
      pin_output_latch      <= next_pin_output_latch;
      state                 <= next_state;
      cnt                   <= next_cnt;
      so_latch              <= next_so_latch;
      sck_d                 <= next_sck_d;
    end
  end

  // output selector is combinational so config writes show at once
  always_comb
  begin
    if (cfg.enable)
    begin
      serial_out_value = so_latch;
    end
    else if (!cfg.trmd)
    begin
      serial_out_value = 1'b0;
    end
    else if (!cfg.dap)
    begin
      serial_out_value = so_latch;
    end
    else
    begin
      serial_out_value = first_bit(transmit_buffer, cfg.dir);
    end
  end

  // the port latch must be low for the serial value to pass to the pin
  assign o_serial_out_line = serial_out_value | pin_output_latch;
  assign o_serial_out_oe   = ~pin_direction_setting;
  assign o_irq             = done_st & done_mask;

endmodule

// *** dv/csp_top_properties.sv ***
// Purpose: port-level checks of the clocked serial output path
// Assumes: one wait state per bus access, serial clock sampled on i_mclk
// Notes:   sck_age spans the synchroniser delay, so output moves are tied to their cause
module csp_chk
  import csp_pkg::*;
#(
  parameter int unsigned DATA_W = BITS_PER_XFER
) (
  input wire logic              i_mclk,
  input wire logic              i_rst_n,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic              i_avs_read,
  input wire logic              i_avs_write,
  input wire logic [31:0]       i_avs_writedata,
  input wire logic [3:0]        i_avs_byteenable,
  input wire logic [31:0]       o_avs_readdata,
  input wire logic              o_avs_waitrequest,
  input wire logic              i_serial_clock_line,
  input wire logic              i_serial_in_line,
  input wire logic              o_serial_out_line,
  input wire logic              o_serial_out_oe,
  input wire logic              o_irq
);
  logic       sck_q;
  logic [3:0] sck_age;
  logic       next_sck_q;
  logic [3:0] next_sck_age;

  always_comb
  begin
    next_sck_q   = i_serial_clock_line;
    next_sck_age = (i_serial_clock_line != sck_q) ? 4'h0 : ((sck_age == 4'hF) ? 4'hF : sck_age + 4'h1);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sck_q   <= 1'b0;
      sck_age <= 4'hF;
    end
    else
    begin
      sck_q   <= next_sck_q;
      sck_age <= next_sck_age;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  chk_wait_first: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
    else $error("waitrequest low in first request cycle");
  chk_ack_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered after one wait state");
  chk_idle_nowait: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
    else $error("waitrequest high without request");
  chk_rd_hold: assert property ($changed(o_avs_readdata) |-> $past(i_avs_read))
    else $error("read data moved without a read");
  chk_rd_upper: assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0)
    else $error("read data wider than a byte");
  chk_rst_quiet: assert property ($rose(i_rst_n) |-> !o_serial_out_line && !o_serial_out_oe && !o_irq)
    else $error("outputs not quiet after reset");
  chk_out_cause: assert property ($changed(o_serial_out_line) |->
      $past(i_avs_write || i_avs_read) || sck_age < 4'h8)
    else $error("serial output moved without clock edge or access");
  chk_oe_cause: assert property ($changed(o_serial_out_oe) |-> $past(i_avs_write))
    else $error("pin enable moved without a write");
  chk_irq_rise: assert property ($rose(o_irq) |-> $past(i_avs_write) || sck_age < 4'h8)
    else $error("interrupt rose without cause");
  chk_irq_fall: assert property ($fell(o_irq) |-> $past(i_avs_write))
    else $error("interrupt fell without a write");
endmodule

bind csp_top csp_chk #(.DATA_W(DATA_W)) u_chk (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_serial_clock_line(i_serial_clock_line), .i_serial_in_line(i_serial_in_line),
  .o_serial_out_line(o_serial_out_line), .o_serial_out_oe(o_serial_out_oe), .o_irq(o_irq)
);

// *** dv/csp_peer.sv ***
// Purpose: behavioural peripheral that clocks frames into the serial path
// Assumes: clock idles at the inverse of the polarity bit, 200 ns period
// Notes:   input line shows the inverse of its last bit between frames
module csp_peer (
  output logic      o_sck,
  output logic      o_sdi,
  input  wire logic i_so
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx;

  initial
  begin
    o_sck = 1'b1;
    o_sdi = 1'b0;
  end

  task automatic park(input logic ckp);
    #3 o_sck = !ckp;
  endtask

  // capture rising for 00 and 11, falling for 01 and 10
  task automatic frame(input logic ckp, input logic dap, input logic ord, input logic [7:0] tx, input int nb);
    logic cap;
    cap = !(ckp ^ dap);
    #7;
    for (int i = 0; i < nb; i++)
    begin
      o_sdi = ord ? tx[i] : tx[7-i];
      if (!dap)
        o_sck = !cap;
      #100;
      rx = ord ? {i_so, rx[7:1]} : {rx[6:0], i_so};
      o_sck = cap;
      #100;
      if (dap)
        o_sck = !cap;
    end
    o_sck = !ckp;
    o_sdi = !o_sdi;
  endtask
endmodule

// *** dv/csp_top_tb_top.sv ***
// Purpose: self-checking bench of the serial output path
// Assumes: peer model owns the serial clock and input line
// Notes:   byteenable high except for one masked write, lane 0 carries all fields
module csp_top_tb_top
  import csp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n;
  logic [4:0]  adr;
  logic        rd;
  logic        we;
  logic [31:0] wdat;
  logic [31:0] rdata;
  logic        wreq;
  logic        sck;
  logic        sdi;
  logic        so;
  logic        oe;
  logic        irq;
  logic [31:0] q;
  logic [3:0]  be;
  int          miscompares = 0;
  int          tests_run = 0;

  always #12.5 clk = !clk;

  csp_top u_dut (
    .i_mclk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(we),
    .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_serial_clock_line(sck), .i_serial_in_line(sdi), .o_serial_out_line(so), .o_serial_out_oe(oe), .o_irq(irq)
  );
  csp_peer u_peer (.o_sck(sck), .o_sdi(sdi), .i_so(so));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr  <= a;
    wdat <= d;
    rd   <= !wr;
    we   <= wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    // read data still stand at the edge that ends the wait
    q = rdata;
    rd <= 1'b0;
    we <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  // pins are looked at mid-cycle, never in the step of the edge that moves them
  task automatic pin(input logic e);
    @(negedge clk);
    chk({31'h0, so}, {31'h0, e});
  endtask

  task automatic oec(input logic e);
    @(negedge clk);
    chk({31'h0, oe}, {31'h0, e});
  endtask

  task automatic t_reset;
    logic [4:0] a [8] = '{OFS_CTRL, OFS_CLKSEL, OFS_TXBUF, OFS_SHIFT, OFS_IRQ_ST, OFS_IRQ_MSK, OFS_PIN, 5'h1C};
    pin(1'b0);
    chk({30'h0, oe, irq}, 32'h0);
    foreach (a[i]) rdc(a[i], (a[i] == OFS_PIN) ? 32'h1 : 32'h0);
  endtask

  task automatic t_xfer(input logic ckp, dap, ord, mode, msk, input logic [7:0] d, pb);
    logic [31:0] ctl;
    int n;
    ctl = {24'h0, 1'b1, mode, 1'b0, ord, 4'h0};
    wr(OFS_CTRL, 32'h0);
    u_peer.park(ckp);
    wr(OFS_CLKSEL, {27'h0, ckp, dap, 3'h0});
    wr(OFS_PIN, 32'h0);
    oec(1'b1);
    wr(OFS_IRQ_MSK, {31'h0, msk});
    wr(OFS_CTRL, ctl);
    if (mode)
      wr(OFS_TXBUF, {24'h0, d});
    else
      bus(1'b0, OFS_SHIFT, 32'h0);
    rdc(OFS_CTRL, ctl | 32'h1);
    if (mode && dap) pin(ord ? d[0] : d[7]);
    u_peer.frame(ckp, dap, ord, pb, 8);
    n = 0;
    do
    begin
      bus(1'b0, OFS_CTRL, 32'h0);
      n++;
    end
    while (q[0] !== 1'b0 && n < 20);
    chk(q, ctl);
    if (mode) chk({24'h0, u_peer.rx}, {24'h0, d});
    if (mode) pin(ord ? d[7] : d[0]);
    rdc(OFS_SHIFT, {24'h0, pb});
    chk({31'h0, irq}, {31'h0, msk});
    rdc(OFS_IRQ_ST, 32'h1);
    wr(OFS_IRQ_ST, 32'h1);
    rdc(OFS_IRQ_ST, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_abort;
    wr(OFS_CTRL, 32'h0);
    u_peer.park(1'b0);
    wr(OFS_CLKSEL, 32'h0);
    wr(OFS_CTRL, 32'hC0);
    wr(OFS_TXBUF, 32'hF0);
    u_peer.frame(1'b0, 1'b0, 1'b0, 8'h55, 3);
    wr(OFS_CTRL, 32'h0);
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_SHIFT, 32'h0);
  endtask

  // after the first two setup writes, each write is followed by a look at the pin or its enable in the next cycle
  task automatic t_disabled;
    wr(OFS_CLKSEL, 32'h08);
    wr(OFS_TXBUF, 32'h80);
    wr(OFS_CTRL, 32'h40);
    pin(1'b1);
    wr(OFS_CTRL, 32'h50);
    pin(1'b0);
    wr(OFS_TXBUF, 32'h01);
    pin(1'b1);
    wr(OFS_CLKSEL, 32'h00);
    pin(1'b0);
    wr(OFS_CTRL, 32'h00);
    pin(1'b0);
    wr(OFS_PIN, 32'h2);
    pin(1'b1);
    wr(OFS_PIN, 32'h1);
    oec(1'b0);
    // a write without lane 0 must leave the pin settings alone
    be <= 4'hE;
    wr(OFS_PIN, 32'h0);
    be <= 4'hF;
    oec(1'b0);
    rdc(OFS_PIN, 32'h1);
  endtask

  task automatic summarize;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #300us;
    miscompares++;
    summarize;
  end

  initial
  begin
    rst_n = 1'b0;
    adr   = 5'h0;
    rd    = 1'b0;
    we    = 1'b0;
    wdat  = 32'h0;
    be    = 4'hF;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_xfer(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'hA4, 8'h3C);
    t_xfer(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 8'h96, 8'hC1);
    t_xfer(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h5A, 8'h0F);
    t_xfer(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h83, 8'h7E);
    t_xfer(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'hE7);
    t_abort;
    t_disabled;
    summarize;
  end
endmodule
